// ---- rtl/fmt_top.sv ----
/*
  frequency measurement of a selected audio clock and crystal trim
  pulse-density output, with a plain register port.
  assumes all bus signals are synchronous to core_clk and the audio
  clocks are asynchronous pins; core_clk is the reference clock.
*/
// How it works
// - source field picks one of four bit clocks or digital input
// - gain field scales the measured value by a fixed multiplier
// - edges of the selected clock become pulses against core clock
// - pulses pass a low-pass filter near 76 Hz bandwidth
// - a further filter stage smooths the value for the oscillator
// - trim pin carries a pulse-density modulated signal
// - one 16-bit read-write trim register sets the pin
// - trim register resets to 0x8000, half duty
// - duty follows trim value: zero, half, full
// - trim pin comes from a first-order modulator
// - modulator steps once every 16 system clocks
// - result is 32 bits read-only, top of a 48-bit filter
// - result scales with frequency, doubled for bit clocks
`timescale 1ns/100ps

module fmt_top
  import fmt_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [`FMT_ADDR_W-1:0] reg_addr,
  input wire logic [`FMT_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`FMT_DATA_W-1:0] reg_rdata,
  // audio clock pins
  input wire logic audio_bit_clock_one,
  input wire logic audio_bit_clock_two,
  input wire logic audio_bit_clock_three,
  input wire logic audio_bit_clock_four,
  input wire logic digital_audio_input,
  // results
  output logic [31:0] measured_frequency_value,
  output logic [31:0] dto_increment,
  output logic crystal_trim_out
);

  fmt_core_st_t st_ff;
  fmt_core_st_t nxt_st;
  logic meas_pulse;
  logic [`FMT_ACC_W-1:0] lpf_in;
  logic [31:0] gain_mult;

  // ==========================================================
  // edge detection on the selected clock
  fmt_edge_det u_edge (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .raw_clk({digital_audio_input, audio_bit_clock_four,
              audio_bit_clock_three, audio_bit_clock_two,
              audio_bit_clock_one}),
    .src_sel(st_ff.src),
    .pulse_o(meas_pulse)
  );

  // ==========================================================
  // crystal trim modulator
  fmt_pdm u_pdm (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .trim_i(st_ff.trim),
    .pdm_o(crystal_trim_out)
  );

  // ==========================================================
  // next state: register writes, reads and filter
  always_comb begin
    nxt_st = st_ff;
    gain_mult = fmt_gain(st_ff.gain);
    // each pulse injects gain with 16 fraction bits below
    lpf_in = meas_pulse ? {gain_mult, `FMT_FRAC_BITS'(0)}
                        : `FMT_ACC_W'(0);

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        `FMT_OFS_CONFIG: begin
          nxt_st.src = reg_wdata[`FMT_CFG_SRC_LSB +: `FMT_FIELD_W];
          nxt_st.gain = reg_wdata[`FMT_CFG_GAIN_LSB +: `FMT_FIELD_W];
        end
        `FMT_OFS_TRIM: begin
          nxt_st.trim = reg_wdata[15:0];
        end
        default: begin
        end
      endcase
    end

    // read data stands for one cycle after the strobe
    nxt_st.rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        `FMT_OFS_CONFIG: begin
          nxt_st.rdata = {26'h0, st_ff.gain, st_ff.src};
        end
        `FMT_OFS_TRIM: begin
          nxt_st.rdata = {16'h0, st_ff.trim};
        end
        `FMT_OFS_FREQ: begin
          nxt_st.rdata = st_ff.lpf_b[`FMT_ACC_W-1 -: 32];
        end
        default: begin
        end
      endcase
    end

    // two poles form the measurement, a third smooths it further
    nxt_st.lpf_a = fmt_lpf(st_ff.lpf_a, lpf_in);
    nxt_st.lpf_b = fmt_lpf(st_ff.lpf_b, st_ff.lpf_a);
    nxt_st.lpf_c = fmt_lpf(st_ff.lpf_c, st_ff.lpf_b);
  end

  // ==========================================================
  // state register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_ff.src <= `FMT_SRC_RST;
      st_ff.gain <= `FMT_GAIN_RST;
      st_ff.trim <= `FMT_TRIM_RST;
      st_ff.rdata <= 32'h0000_0000;
      st_ff.lpf_a <= `FMT_ACC_W'(0);
      st_ff.lpf_b <= `FMT_ACC_W'(0);
      st_ff.lpf_c <= `FMT_ACC_W'(0);
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata = st_ff.rdata;
  assign measured_frequency_value = st_ff.lpf_b[`FMT_ACC_W-1 -: 32];
  assign dto_increment = st_ff.lpf_c[`FMT_ACC_W-1 -: 32];

  // ==========================================================
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_cfg_write;
    reg_wr && reg_addr == `FMT_OFS_CONFIG;
  endsequence

  sequence s_trim_read;
    reg_rd && reg_addr == `FMT_OFS_TRIM;
  endsequence

  sequence s_freq_read;
    reg_rd && reg_addr == `FMT_OFS_FREQ;
  endsequence

  sequence s_trim_write;
    reg_wr && reg_addr == `FMT_OFS_TRIM;
  endsequence

  sequence s_cfg_read;
    reg_rd && reg_addr == `FMT_OFS_CONFIG;
  endsequence

  sequence s_freq_write;
    reg_wr && reg_addr == `FMT_OFS_FREQ;
  endsequence

  sequence s_other_read;
    reg_rd && reg_addr != `FMT_OFS_CONFIG && reg_addr != `FMT_OFS_TRIM
      && reg_addr != `FMT_OFS_FREQ;
  endsequence

  a_trim_reset: assert property (
    $fell(sys_rst) |-> st_ff.trim == `FMT_TRIM_RST)
    else $error("trim not at half scale after reset");

  a_cfg_write: assert property (
    s_cfg_write |=> st_ff.src == $past(reg_wdata[2:0])
                 && st_ff.gain == $past(reg_wdata[5:3]))
    else $error("config write not taken");

  a_trim_write: assert property (
    reg_wr && reg_addr == `FMT_OFS_TRIM ##1 s_trim_read
      |=> reg_rdata == {16'h0, $past(reg_wdata[15:0], 2)})
    else $error("trim read back differs from write");

  a_freq_read: assert property (
    s_freq_read |=> reg_rdata == $past(measured_frequency_value))
    else $error("frequency read wrong");

  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data without read strobe");

  a_filter_rise: assert property (
    meas_pulse && gain_mult != 32'h0 && st_ff.lpf_a == `FMT_ACC_W'(0)
      |=> st_ff.lpf_a != `FMT_ACC_W'(0))
    else $error("pulse did not raise the filter");

  a_gain_reserved: assert property (
    st_ff.gain == 3'h7 |-> lpf_in == `FMT_ACC_W'(0))
    else $error("reserved gain injected a value");

  a_smooth_follow: assert property (
    st_ff.lpf_b == st_ff.lpf_c ##1 st_ff.lpf_b == st_ff.lpf_c
      |-> st_ff.lpf_c == $past(st_ff.lpf_c))
    else $error("smoothing stage moved without input change");

  a_trim_take: assert property (
    s_trim_write |=> st_ff.trim == $past(reg_wdata[15:0]))
    else $error("trim write not taken");

  a_trim_hold: assert property (
    !(reg_wr && reg_addr == `FMT_OFS_TRIM) |=> $stable(st_ff.trim))
    else $error("trim changed without a write");

  a_cfg_hold: assert property (
    !(reg_wr && reg_addr == `FMT_OFS_CONFIG)
      |=> $stable(st_ff.src) && $stable(st_ff.gain))
    else $error("config changed without a write");

  a_trim_read: assert property (
    s_trim_read |=> reg_rdata == {16'h0000, $past(st_ff.trim)})
    else $error("trim read wrong");

  a_cfg_read: assert property (
    s_cfg_read
      |=> reg_rdata == {26'h0, $past(st_ff.gain), $past(st_ff.src)})
    else $error("config read wrong");

  a_other_read: assert property (
    s_other_read |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  a_freq_ro: assert property (
    s_freq_write |=> $stable(st_ff.src) && $stable(st_ff.gain)
                  && $stable(st_ff.trim))
    else $error("write to frequency result changed a register");

  a_cfg_reset: assert property (
    $fell(sys_rst) |-> st_ff.src == `FMT_SRC_RST
                    && st_ff.gain == `FMT_GAIN_RST)
    else $error("config not cleared by reset");

  a_meas_reset: assert property (
    $fell(sys_rst) |-> measured_frequency_value == 32'h0000_0000
                    && dto_increment == 32'h0000_0000)
    else $error("measurement not cleared by reset");

  // filter stages move only toward their input
  a_filter_decay: assert property (
    !meas_pulse |=> st_ff.lpf_a <= $past(st_ff.lpf_a))
    else $error("first pole rose without a pulse");

  a_stage_rise: assert property (
    st_ff.lpf_a >= st_ff.lpf_b |=> st_ff.lpf_b >= $past(st_ff.lpf_b))
    else $error("second pole fell below a higher input");

  a_stage_fall: assert property (
    st_ff.lpf_a <= st_ff.lpf_b |=> st_ff.lpf_b <= $past(st_ff.lpf_b))
    else $error("second pole rose above a lower input");

  a_smooth_rise: assert property (
    st_ff.lpf_b >= st_ff.lpf_c |=> st_ff.lpf_c >= $past(st_ff.lpf_c))
    else $error("smoothing pole fell below a higher input");

  a_smooth_fall: assert property (
    st_ff.lpf_b <= st_ff.lpf_c |=> st_ff.lpf_c <= $past(st_ff.lpf_c))
    else $error("smoothing pole rose above a lower input");

  // multiplier per gain code
  a_gain_zero: assert property (
    st_ff.gain == 3'h0 |-> gain_mult == 32'h0003_0000)
    else $error("gain code 0 gives wrong multiplier");

  a_gain_one: assert property (
    st_ff.gain == 3'h1 |-> gain_mult == 32'h0002_0000)
    else $error("gain code 1 gives wrong multiplier");

  a_gain_two: assert property (
    st_ff.gain == 3'h2 |-> gain_mult == 32'h0001_8000)
    else $error("gain code 2 gives wrong multiplier");

  a_gain_three: assert property (
    st_ff.gain == 3'h3 |-> gain_mult == 32'h0001_0000)
    else $error("gain code 3 gives wrong multiplier");

  a_gain_four: assert property (
    st_ff.gain == 3'h4 |-> gain_mult == 32'h0000_c000)
    else $error("gain code 4 gives wrong multiplier");

  a_gain_five: assert property (
    st_ff.gain == 3'h5 |-> gain_mult == 32'h0000_8000)
    else $error("gain code 5 gives wrong multiplier");

  a_gain_six: assert property (
    st_ff.gain == 3'h6 |-> gain_mult == 32'h0000_6000)
    else $error("gain code 6 gives wrong multiplier");

endmodule : fmt_top

// ---- rtl/fmt_cfg.svh ----
/*
  constants of the frequency measure and crystal trim block:
  register offsets, field positions, reset values and counts.
  assumes it is included by bare name from the package and modules.
*/
`ifndef FMT_CFG_SVH
`define FMT_CFG_SVH

// ==========================================================
// register map (byte offsets on the plain register port)
`define FMT_ADDR_W 8
`define FMT_DATA_W 32
`define FMT_OFS_CONFIG 8'ha3
`define FMT_OFS_TRIM 8'ha6
`define FMT_OFS_FREQ 8'ha8

// ==========================================================
// config fields
`define FMT_FIELD_W 3
`define FMT_CFG_SRC_LSB 0
`define FMT_CFG_GAIN_LSB 3
`define FMT_SRC_RST 3'h0
`define FMT_GAIN_RST 3'h0
`define FMT_SRC_DAI 3'h4
`define FMT_TRIM_RST 16'h8000
`define FMT_TRIM_FULL 16'hffff

// ==========================================================
// gain multipliers, 6*2^15 down to 3*2^13
`define FMT_GAIN_C0 32'h0003_0000
`define FMT_GAIN_C1 32'h0002_0000
`define FMT_GAIN_C2 32'h0001_8000
`define FMT_GAIN_C3 32'h0001_0000
`define FMT_GAIN_C4 32'h0000_c000
`define FMT_GAIN_C5 32'h0000_8000
`define FMT_GAIN_C6 32'h0000_6000

// ==========================================================
// filter and modulator timing
`define FMT_ACC_W 48
`define FMT_FRAC_BITS 16
// one pole at 125 MHz / (2*pi*2^18), near 76 Hz
`define FMT_LPF_SHIFT 18
`define FMT_PDM_DIV 16
`define FMT_PDM_DIV_W 4

`endif

// ---- rtl/fmt_pkg.sv ----
/*
  types and shared arithmetic of the frequency measure and trim block.
  assumes fmt_cfg.svh is on the include path.
*/
`include "fmt_cfg.svh"

package fmt_pkg;

  // ==========================================================
  // state records
  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic last;
    logic pulse;
  } fmt_edge_st_t;

  typedef struct packed {
    logic [`FMT_PDM_DIV_W-1:0] div;
    logic [15:0] acc;
    logic out;
  } fmt_pdm_st_t;

  typedef struct packed {
    logic [2:0] src;
    logic [2:0] gain;
    logic [15:0] trim;
    logic [31:0] rdata;
    logic [`FMT_ACC_W-1:0] lpf_a;
    logic [`FMT_ACC_W-1:0] lpf_b;
    logic [`FMT_ACC_W-1:0] lpf_c;
  } fmt_core_st_t;

  // ==========================================================
  // gain code to multiplier; reserved code gives zero
  function automatic logic [31:0] fmt_gain(input logic [2:0] code);
    case (code)
      3'h0: fmt_gain = `FMT_GAIN_C0;
      3'h1: fmt_gain = `FMT_GAIN_C1;
      3'h2: fmt_gain = `FMT_GAIN_C2;
      3'h3: fmt_gain = `FMT_GAIN_C3;
      3'h4: fmt_gain = `FMT_GAIN_C4;
      3'h5: fmt_gain = `FMT_GAIN_C5;
      3'h6: fmt_gain = `FMT_GAIN_C6;
      default: fmt_gain = 32'h0000_0000;
    endcase
  endfunction : fmt_gain

  // one-pole low-pass step: y + (x - y) / 2^shift
  function automatic logic [`FMT_ACC_W-1:0] fmt_lpf(
    input logic [`FMT_ACC_W-1:0] y,
    input logic [`FMT_ACC_W-1:0] x
  );
    logic signed [`FMT_ACC_W:0] d;
    d = $signed({1'b0, x}) - $signed({1'b0, y});
    fmt_lpf = y + `FMT_ACC_W'(d >>> `FMT_LPF_SHIFT);
  endfunction : fmt_lpf

endpackage : fmt_pkg

// ---- rtl/fmt_edge_det.sv ----
/*
  edge pulse from the selected audio clock.
  assumes the clock inputs are asynchronous to core_clk and that
  core_clk is faster than twice the fastest selected clock.
*/
`timescale 1ns/100ps

module fmt_edge_det
  import fmt_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // raw clocks: four bit clocks, then digital audio input
  input wire logic [4:0] raw_clk,
  // selection and result
  input wire logic [2:0] src_sel,
  output logic pulse_o
);

  fmt_edge_st_t st_ff;
  fmt_edge_st_t nxt_st;
  logic lvl;

  // ==========================================================
  // synchronise, select, detect
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = raw_clk;
    nxt_st.s2 = st_ff.s1;
    lvl = (src_sel <= `FMT_SRC_DAI) ? st_ff.s2[src_sel] : 1'b0;
    nxt_st.last = lvl;
    case (src_sel)
      3'h0, 3'h1, 3'h2, 3'h3: nxt_st.pulse = lvl ^ st_ff.last;
      `FMT_SRC_DAI: nxt_st.pulse = lvl & ~st_ff.last;
      default: nxt_st.pulse = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pulse_o = st_ff.pulse;

  // ==========================================================
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_edge_bitclk: assert property (
    (src_sel == 3'h0 && st_ff.s2[0] != st_ff.last) |=> pulse_o)
    else $error("bit clock edge gave no pulse");

  a_edge_reserved: assert property (
    (src_sel > `FMT_SRC_DAI) |=> !pulse_o)
    else $error("reserved source gave a pulse");

endmodule : fmt_edge_det

// ---- rtl/fmt_pdm.sv ----
/*
  first-order pulse-density modulator for the crystal trim pin.
  assumes trim_i comes from a register on core_clk.
*/
`timescale 1ns/100ps

module fmt_pdm
  import fmt_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // duty value and output
  input wire logic [15:0] trim_i,
  output logic pdm_o
);

  fmt_pdm_st_t st_ff;
  fmt_pdm_st_t nxt_st;
  logic tick;
  logic [16:0] sum;

  // ==========================================================
  // divide by 16, accumulate, carry drives the pin
  always_comb begin
    nxt_st = st_ff;
    tick = (st_ff.div == `FMT_PDM_DIV_W'(`FMT_PDM_DIV - 1));
    sum = {1'b0, st_ff.acc} + {1'b0, trim_i};
    nxt_st.div = st_ff.div + `FMT_PDM_DIV_W'(1);
    if (tick) begin
      nxt_st.acc = sum[15:0];
      nxt_st.out = sum[16] | (trim_i == `FMT_TRIM_FULL);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pdm_o = st_ff.out;

  // ==========================================================
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_tick_period: assert property (
    tick |=> (!tick) [*8] ##1 (!tick) [*7] ##1 tick)
    else $error("modulator tick not every 16 clocks");

  a_pdm_carry: assert property (
    tick && trim_i != `FMT_TRIM_FULL
      |=> (pdm_o == $past(sum[16])) ##1 ($stable(pdm_o)) [*8])
    else $error("output does not follow accumulator carry");

  a_duty_zero: assert property (
    tick && trim_i == 16'h0000 |=> !pdm_o)
    else $error("zero duty drove output high");

  a_duty_full: assert property (
    tick && trim_i == `FMT_TRIM_FULL |=> pdm_o)
    else $error("full duty drove output low");

endmodule : fmt_pdm

// ---- sim/fmt_xtal_model.sv ----
/*
  model of the varicap crystal circuit on the trim pin.
  assumes the pin is sampled on core_clk; win_clr opens a new window.
*/
`timescale 1ns/100ps

module fmt_xtal_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // trim pin and window
  input wire logic trim_pin,
  input wire logic win_clr,
  output logic [31:0] high_cnt
);
  // ==========================================================
  // varicap integrates the pin: high time over a window
  always_ff @(posedge core_clk) begin
    if (sys_rst || win_clr) begin
      high_cnt <= 32'h0;
    end else begin
      high_cnt <= high_cnt + {31'h0, trim_pin};
    end
  end
endmodule : fmt_xtal_model

// ---- sim/tb_fmt_top.sv ----
/*
  self-checking bench of the frequency measure and trim block.
  assumes the rtl files and fmt_xtal_model are compiled before it.
*/
`timescale 1ns/100ps
`include "fmt_cfg.svh"

module tb_fmt_top;
  // ==========================================================
  // signals
  typedef struct {
    logic wr;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } fmt_row_t;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, meas, dto, high_cnt, q;
  logic [4:0] pins = 5'h0;
  logic [4:0] pin_en = 5'h0;
  logic tgl = 1'b0;
  logic trim_pin;
  logic win_clr = 1'b0;
  logic [31:0] v[8];
  logic [15:0] trims[5] = '{16'h0, 16'h4000, 16'h8000, 16'hc000, 16'hffff};
  int muls[7] = '{24, 16, 12, 8, 6, 4, 3};
  int fails = 0;
  int checks = 0;
  int n;
  fmt_row_t rows[] = '{
    '{1, `FMT_OFS_TRIM, 32'h1234, 0}, '{0, `FMT_OFS_TRIM, 0, 32'h1234},
    '{1, `FMT_OFS_TRIM, 32'habcd_5678, 0}, '{0, `FMT_OFS_TRIM, 0, 32'h5678},
    '{1, `FMT_OFS_CONFIG, 32'hffff_ffff, 0}, '{0, `FMT_OFS_CONFIG, 0, 32'h3f},
    '{1, `FMT_OFS_CONFIG, 32'h2c, 0}, '{0, `FMT_OFS_CONFIG, 0, 32'h2c},
    '{1, `FMT_OFS_FREQ, 32'h5555_5555, 0}, '{0, `FMT_OFS_FREQ, 0, 0},
    '{1, 8'h40, 32'hffff_ffff, 0}, '{0, 8'h40, 0, 0}, '{0, 8'ha7, 0, 0},
    '{1, `FMT_OFS_CONFIG, 0, 0}, '{0, `FMT_OFS_CONFIG, 0, 0},
    '{1, `FMT_OFS_TRIM, 32'h8000, 0}, '{0, `FMT_OFS_TRIM, 0, 32'h8000}};

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  // audio pins toggle every second cycle when enabled
  always @(posedge core_clk) begin
    tgl <= ~tgl;
    if (tgl) pins <= pins ^ pin_en;
  end

  fmt_top i_fmt_top (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .audio_bit_clock_one(pins[0]), .audio_bit_clock_two(pins[1]),
    .audio_bit_clock_three(pins[2]), .audio_bit_clock_four(pins[3]),
    .digital_audio_input(pins[4]), .measured_frequency_value(meas),
    .dto_increment(dto), .crystal_trim_out(trim_pin));

  fmt_xtal_model i_fmt_xtal_model (.core_clk(core_clk),
    .sys_rst(sys_rst), .trim_pin(trim_pin), .win_clr(win_clr),
    .high_cnt(high_cnt));

  // ==========================================================
  // tasks
  task automatic chk_val(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic chk_in(input string what, input int lo, input int hi,
    input logic [31:0] got);
    checks++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      fails++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_in

  task automatic do_reset;
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
  endtask : do_reset

  task automatic reg_op(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge core_clk);
    reg_wr <= wr;
    reg_rd <= ~wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
  endtask : reg_op

  task automatic meas_run(input logic [2:0] src, input logic [2:0] gain,
    input logic [4:0] en, output logic [31:0] r);
    do_reset();
    reg_op(1'b1, `FMT_OFS_CONFIG, {26'h0, gain, src}, q);
    pin_en <= en;
    repeat (5000) @(posedge core_clk);
    pin_en <= 5'h0;
    #1 r = meas;
  endtask : meas_run

  task automatic wait_edge(output int c);
    logic s;
    s = trim_pin;
    c = 0;
    while ((trim_pin === s) && (c < 64)) begin
      @(posedge core_clk);
      #1 c++;
    end
  endtask : wait_edge

  task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if ((fails == 0) && (checks > 0)) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================
  // main sequence
  initial begin
    do_reset();
    #1 chk_val("meas_reset", 32'h0, meas);
    chk_val("dto_reset", 32'h0, dto);
    reg_op(1'b0, `FMT_OFS_TRIM, 0, q);
    chk_val("trim_reset", 32'h8000, q);
    reg_op(1'b0, `FMT_OFS_CONFIG, 0, q);
    chk_val("config_reset", 32'h0, q);
    $display("test reset done");
    foreach (rows[i]) begin
      reg_op(rows[i].wr, rows[i].a, rows[i].d, q);
      if (!rows[i].wr) begin
        chk_val("reg_rdata", rows[i].e, q);
        @(posedge core_clk);
        #1 chk_val("rdata_idle", 32'h0, reg_rdata);
      end
    end
    // write then read with no gap
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= `FMT_OFS_TRIM;
    reg_wdata <= 32'h0000_9abc;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk_val("trim_back_to_back", 32'h9abc, reg_rdata);
    $display("test registers done");
    for (int k = 0; k < 5; k++) begin
      meas_run(k[2:0], 3'h0, 5'h1 << k, v[k]);
      chk_in("meas_selected", 1, 32'h7fff_ffff, v[k]);
      chk_in("dto_below_meas", 0, v[k], dto);
    end
    chk_in("meas_bit_vs_dai", 2 * v[4] - 3, 2 * v[4] + 3, v[0]);
    meas_run(3'h1, 3'h0, 5'h01, v[5]);
    chk_val("meas_unselected", 32'h0, v[5]);
    meas_run(3'h7, 3'h0, 5'h1f, v[7]);
    chk_val("meas_reserved", 32'h0, v[7]);
    for (int g = 1; g < 7; g++) begin
      meas_run(3'h0, g[2:0], 5'h01, v[6]);
      n = v[0] * muls[g] / 24;
      chk_in("meas_gain", n - 2, n + 2, v[6]);
    end
    $display("test measurement done");
    do_reset();
    wait_edge(n);
    wait_edge(n);
    chk_val("trim_run_a", 32'h10, n);
    wait_edge(n);
    chk_val("trim_run_b", 32'h10, n);
    foreach (trims[i]) begin
      reg_op(1'b1, `FMT_OFS_TRIM, {16'h0, trims[i]}, q);
      repeat (40) @(posedge core_clk);
      win_clr <= 1'b1;
      @(posedge core_clk);
      win_clr <= 1'b0;
      repeat (4096) @(posedge core_clk);
      n = (trims[i] == 16'hffff) ? 4096 : trims[i] >> 4;
      #1 chk_val("trim_duty", n, high_cnt);
    end
    $display("test trim done");
    wrap_up();
  end

  initial begin
    #(8 * 95000);
    fails++;
    $display("Error watchdog expected done seen hang");
    wrap_up();
  end
endmodule : tb_fmt_top
